// >>> verilog/oss_regs.svh
// register offsets, field positions, reset values and counts for the oscillator source switch
// assumes an 8-bit register port with a 2-bit word address
`ifndef OSS_REGS_SVH
`define OSS_REGS_SVH

`define OSS_ADDR_CTRL    2'h0
`define OSS_ADDR_TRIM    2'h1
`define OSS_ADDR_CFG     2'h2
`define OSS_ADDR_STATUS  2'h3

`define OSS_CTRL_SRC_LSB    6
`define OSS_CTRL_IFS_LSB    4
`define OSS_CTRL_RANGE_LSB  2
`define OSS_CTRL_REQ_BIT    1
`define OSS_CTRL_ENG_BIT    0
`define OSS_CFG_OCEN_BIT    0
`define OSS_CFG_KEEP_BIT    1

`define OSS_SRC_INT      2'h0
`define OSS_SRC_EXT      2'h1
`define OSS_SRC_RC       2'h2
`define OSS_SRC_XTAL     2'h3
`define OSS_IFS_RESV     2'h3
`define OSS_IFS_RESET    2'h2
`define OSS_RANGE_RESET  2'h0
`define OSS_TRIM_RESET   8'h00
`define OSS_EDGES_NEEDED 2'h2

`endif

// >>> verilog/oss_pkg.sv
// types shared by the oscillator source switch modules
// assumes oss_regs.svh holds the numeric constants
package oss_pkg;

    typedef enum logic [4:0] {
        OSS_ST_INT     = 5'b00001,
        OSS_ST_WAIT    = 5'b00010,
        OSS_ST_SWITCH  = 5'b00100,
        OSS_ST_EXT     = 5'b01000,
        OSS_ST_RESTART = 5'b10000
    } oss_state_e;

    typedef enum logic [1:0] {
        OSS_PIN_GPIO = 2'h0,
        OSS_PIN_CLK  = 2'h1,
        OSS_PIN_AMP  = 2'h2
    } oss_pin_fn_e;

    typedef struct packed {
        logic        out;
        logic        oe;
    } oss_pin_s;

    typedef struct packed {
        oss_state_e  st;
        logic [1:0]  src;
        logic [1:0]  ifs;
        logic [1:0]  range_req;
        logic [1:0]  range_act;
        logic        req;
        logic        eng;
        logic        ocen;
        logic        keep;
        logic [7:0]  trim;
        logic [1:0]  act;
        logic [1:0]  edges;
        logic [3:0]  prev;
        logic        x4;
        logic        int_en;
        logic        in_en;
        oss_pin_fn_e pin_fn;
        oss_pin_s    pin;
        logic [7:0]  rdata;
    } oss_top_s;

    typedef struct packed {
        logic        s1;
        logic        s2;
    } oss_sync_bit_s;

endpackage

// >>> verilog/oss_sync2.sv
// two-flop synchroniser for a vector of asynchronous levels
// assumes each bit is an independent level from outside the clk domain
`timescale 1ns/100ps
module oss_sync2 import oss_pkg::*; #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [2*W-1:0] q_ff;
    logic [2*W-1:0] nxt_q;

    always_comb begin
        nxt_q = {q_ff[W-1:0], din};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign dout = q_ff[2*W-1:W];
endmodule // oss_sync2

// >>> verilog/oss_div2.sv
// halves the sampled times-four clock into the times-two clock
// assumes x4 is a flop output in the clk domain
`timescale 1ns/100ps
module oss_div2 import oss_pkg::*; (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic x4,
    output logic      x2
);
    oss_sync_bit_s q_ff;
    oss_sync_bit_s nxt_q;

    // s1 holds last x4, s2 the halved clock
    always_comb begin
        nxt_q    = q_ff;
        nxt_q.s1 = x4;
        if (x4 && !q_ff.s1) begin
            nxt_q.s2 = !q_ff.s2;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign x2 = q_ff.s2;
endmodule // oss_div2

// >>> verilog/oss_top.sv
// oscillator source switch: register port, source select state machine, pin steering
// assumes analog oscillators outside; their clocks arrive as levels sampled on clk
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "oss_regs.svh"
module oss_top import oss_pkg::*; (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       internal_osc_clk,
    input  wire logic       clock_input_pin,
    input  wire logic       rc_osc_clk,
    input  wire logic       crystal_clk,
    input  wire logic       stop_mode,
    input  wire logic       sys_osc_enable,
    input  wire logic       gpio_out,
    input  wire logic       gpio_oe,
    output logic            clk_times_four,
    output logic            clk_times_two,
    output logic            internal_osc_enable,
    output logic            crystal_amp_enable,
    output logic      [1:0] internal_freq_select,
    output logic      [1:0] crystal_range_select,
    output logic      [7:0] trim_register,
    output logic            in_pin_clock_enable,
    output logic            clock_output_pin_out,
    output logic            clock_output_pin_oe,
    output logic            ext_clock_engaged
);
    oss_top_s   q_ff;
    oss_top_s   nxt_q;
    logic [3:0] clks;
    logic [3:0] rise;
    logic       run;
    logic       x2;

    // bit index equals source select code
    oss_sync2 #(.W(4)) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  ({crystal_clk, rc_osc_clk, clock_input_pin, internal_osc_clk}),
        .dout (clks)
    );

    oss_div2 u_div (
        .clk (clk),
        .rst (rst),
        .x4  (q_ff.x4),
        .x2  (x2)
    );

    function automatic logic lvl(input logic [3:0] v, input logic [1:0] sel);
        lvl = v[sel];
    endfunction

    function automatic logic is_src(input logic [1:0] a, input logic [1:0] b);
        is_src = (a == b);
    endfunction

    assign rise = clks & ~q_ff.prev;
    assign run  = !stop_mode || sys_osc_enable || q_ff.keep;

    always_comb begin
        nxt_q      = q_ff;
        nxt_q.prev = clks;
        nxt_q.rdata = 8'h00;

        // register reads, data in the following cycle
        if (rd) begin
            case (addr)
                `OSS_ADDR_CTRL: begin
                    nxt_q.rdata = {q_ff.src, q_ff.ifs, q_ff.range_req, q_ff.req, q_ff.eng};
                end
                `OSS_ADDR_TRIM: begin
                    nxt_q.rdata = q_ff.trim;
                end
                `OSS_ADDR_CFG: begin
                    nxt_q.rdata = {6'h00, q_ff.keep, q_ff.ocen};
                end
                `OSS_ADDR_STATUS: begin
                    nxt_q.rdata = {q_ff.st, q_ff.int_en, q_ff.act};
                end
                default: begin
                    nxt_q.rdata = 8'h00;
                end
            endcase
        end

        // register writes; engaged bit ignores writes
        if (wr) begin
            case (addr)
                `OSS_ADDR_CTRL: begin
                    nxt_q.src       = wdata[`OSS_CTRL_SRC_LSB +: 2];
                    nxt_q.range_req = wdata[`OSS_CTRL_RANGE_LSB +: 2];
                    nxt_q.req       = wdata[`OSS_CTRL_REQ_BIT];
                    if (wdata[`OSS_CTRL_IFS_LSB +: 2] != `OSS_IFS_RESV) begin
                        nxt_q.ifs = wdata[`OSS_CTRL_IFS_LSB +: 2];
                    end
                    if (!(q_ff.eng && is_src(q_ff.act, `OSS_SRC_XTAL))) begin
                        nxt_q.range_act = wdata[`OSS_CTRL_RANGE_LSB +: 2];
                    end
                end
                `OSS_ADDR_TRIM: begin
                    nxt_q.trim = wdata;
                end
                `OSS_ADDR_CFG: begin
                    nxt_q.ocen = wdata[`OSS_CFG_OCEN_BIT];
                    nxt_q.keep = wdata[`OSS_CFG_KEEP_BIT];
                end
                default: begin
                end
            endcase
        end

        // source switch sequence
        case (q_ff.st)
            OSS_ST_INT: begin
                if (q_ff.req && !is_src(q_ff.src, `OSS_SRC_INT)) begin
                    nxt_q.st    = OSS_ST_WAIT;
                    nxt_q.edges = 2'h0;
                end
            end
            OSS_ST_WAIT: begin
                if (!q_ff.req || is_src(q_ff.src, `OSS_SRC_INT)) begin
                    nxt_q.st = OSS_ST_INT;
                end else if (rise[q_ff.src]) begin
                    nxt_q.edges = q_ff.edges + 2'h1;
                    if (q_ff.edges + 2'h1 == `OSS_EDGES_NEEDED) begin
                        nxt_q.st = OSS_ST_SWITCH;
                    end
                end
            end
            OSS_ST_SWITCH: begin
                // change mux only while both clocks sit low
                if (!q_ff.x4 && !lvl(clks, q_ff.src)) begin
                    nxt_q.act = q_ff.src;
                    nxt_q.eng = 1'b1;
                    nxt_q.st  = OSS_ST_EXT;
                end
            end
            OSS_ST_EXT: begin
                nxt_q.int_en = 1'b0;
                if (!q_ff.req && is_src(q_ff.src, `OSS_SRC_INT)) begin
                    nxt_q.int_en = 1'b1;
                    nxt_q.edges  = 2'h0;
                    nxt_q.st     = OSS_ST_RESTART;
                end
            end
            OSS_ST_RESTART: begin
                if (q_ff.edges == `OSS_EDGES_NEEDED) begin
                    if (!q_ff.x4 && !clks[0]) begin
                        nxt_q.act = `OSS_SRC_INT;
                        nxt_q.eng = 1'b0;
                        nxt_q.st  = OSS_ST_INT;
                    end
                end else if (rise[0]) begin
                    nxt_q.edges = q_ff.edges + 2'h1;
                end
            end
            default: begin
                nxt_q.st = OSS_ST_INT;
            end
        endcase

        if (q_ff.eng && is_src(q_ff.act, `OSS_SRC_EXT)) begin
            nxt_q.ocen = 1'b0;
        end

        // times-four follows the active source, held low when stopped
        nxt_q.x4    = run && lvl(clks, q_ff.act);
        nxt_q.in_en = !is_src(q_ff.src, `OSS_SRC_INT);

        if (is_src(q_ff.src, `OSS_SRC_XTAL)) begin
            nxt_q.pin_fn = OSS_PIN_AMP;
        end else if (is_src(q_ff.src, `OSS_SRC_EXT) || !q_ff.ocen) begin
            nxt_q.pin_fn = OSS_PIN_GPIO;
        end else begin
            nxt_q.pin_fn = OSS_PIN_CLK;
        end

        case (nxt_q.pin_fn)
            OSS_PIN_CLK: begin
                nxt_q.pin = '{out: nxt_q.x4, oe: 1'b1};
            end
            OSS_PIN_AMP: begin
                nxt_q.pin = '{out: 1'b0, oe: 1'b0};
            end
            default: begin
                nxt_q.pin = '{out: gpio_out, oe: gpio_oe};
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q_ff           <= '0;
            q_ff.st        <= OSS_ST_INT;
            q_ff.ifs       <= `OSS_IFS_RESET;
            q_ff.range_req <= `OSS_RANGE_RESET;
            q_ff.range_act <= `OSS_RANGE_RESET;
            q_ff.trim      <= `OSS_TRIM_RESET;
            q_ff.req       <= 1'b0;
            q_ff.int_en    <= 1'b1;
            q_ff.pin_fn    <= OSS_PIN_GPIO;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // no interrupt output and no break-cleared flags exist here
    assign rdata                = q_ff.rdata;
    assign clk_times_four       = q_ff.x4;
    assign clk_times_two        = x2;
    assign internal_osc_enable  = q_ff.int_en && run;
    assign crystal_amp_enable   = is_src(q_ff.src, `OSS_SRC_XTAL) && run;
    assign internal_freq_select = q_ff.ifs;
    assign crystal_range_select = q_ff.range_act;
    assign trim_register        = q_ff.trim;
    assign in_pin_clock_enable  = q_ff.in_en;
    assign clock_output_pin_out = q_ff.pin.out;
    assign clock_output_pin_oe  = q_ff.pin.oe;
    assign ext_clock_engaged    = q_ff.eng;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_eng_then_stop;
        $rose(q_ff.eng) |-> q_ff.int_en ##1 !q_ff.int_en;
    endproperty
    a_eng_then_stop: assert property (p_eng_then_stop) else $error("osc stopped early");

    property p_two_edges;
        (q_ff.st == OSS_ST_SWITCH) |-> (q_ff.edges == 2'h2);
    endproperty
    a_two_edges: assert property (p_two_edges) else $error("switch before two edges");

    property p_ocen_forced;
        (q_ff.eng && q_ff.act == 2'h1) |=> !q_ff.ocen;
    endproperty
    a_ocen_forced: assert property (p_ocen_forced) else $error("enable not forced");

    property p_xtal_pin;
        (q_ff.src == 2'h3) |=> (q_ff.pin_fn == OSS_PIN_AMP) && !q_ff.pin.oe;
    endproperty
    a_xtal_pin: assert property (p_xtal_pin) else $error("pin not dedicated");

    property p_int_release;
        (q_ff.src == 2'h0) |=> !q_ff.in_en;
    endproperty
    a_int_release: assert property (p_int_release) else $error("input pin held");

    property p_reset_vals;
        $past(rst) |-> (q_ff.ifs == 2'h2) && !q_ff.req && (q_ff.trim == 8'h00);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

    property p_return;
        (q_ff.st == OSS_ST_EXT && !q_ff.req && q_ff.src == 2'h0) |=> q_ff.int_en ##1 q_ff.eng;
    endproperty
    a_return: assert property (p_return) else $error("no restart");

    property p_half_rate;
        $changed(clk_times_two) |-> $past(clk_times_four) && !$past(clk_times_four, 2);
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("x2 off x4 edge");

    property p_stop_gate;
        (stop_mode && !sys_osc_enable && !q_ff.keep) |=> !clk_times_four;
    endproperty
    a_stop_gate: assert property (p_stop_gate) else $error("clock in stop");

    property p_range_hold;
        (q_ff.eng && q_ff.act == 2'h3) |=> $stable(q_ff.range_act);
    endproperty
    a_range_hold: assert property (p_range_hold) else $error("range changed");

    property p_cov_engage;
        $rose(q_ff.eng);
    endproperty
    c_engage: cover property (p_cov_engage);

    property p_cov_back;
        $fell(q_ff.eng);
    endproperty
    c_back: cover property (p_cov_back);

    property p_cov_clkpin;
        q_ff.pin_fn == OSS_PIN_CLK;
    endproperty
    c_clkpin: cover property (p_cov_clkpin);

    property p_cov_xtal_eng;
        q_ff.eng && q_ff.act == 2'h3;
    endproperty
    c_xtal_eng: cover property (p_cov_xtal_eng);

    property p_cov_rc_clkpin;
        q_ff.src == 2'h2 && q_ff.pin_fn == OSS_PIN_CLK;
    endproperty
    c_rc_clkpin: cover property (p_cov_rc_clkpin);

    property p_eng_from_switch;
        $rose(q_ff.eng) |-> ($past(q_ff.st) == OSS_ST_SWITCH);
    endproperty
    a_eng_from_switch: assert property (p_eng_from_switch) else $error("engaged off switch");

    property p_int_off_ext;
        (q_ff.st == OSS_ST_EXT && $past(q_ff.st) == OSS_ST_EXT) |-> !q_ff.int_en;
    endproperty
    a_int_off_ext: assert property (p_int_off_ext) else $error("osc left running");

    property p_restart_int;
        (q_ff.st == OSS_ST_RESTART) |-> q_ff.int_en;
    endproperty
    a_restart_int: assert property (p_restart_int) else $error("osc not restarted");

    property p_act_int;
        !q_ff.eng |-> (q_ff.act == 2'h0);
    endproperty
    a_act_int: assert property (p_act_int) else $error("source without engaged");

    property p_in_en_ext;
        (q_ff.src != 2'h0) |=> q_ff.in_en;
    endproperty
    a_in_en_ext: assert property (p_in_en_ext) else $error("input pin not enabled");

    property p_amp_en;
        (q_ff.src == 2'h3 && !stop_mode) |-> crystal_amp_enable;
    endproperty
    a_amp_en: assert property (p_amp_en) else $error("amplifier off");

    property p_clk_pin;
        (q_ff.src == 2'h0 && q_ff.ocen) |=> (q_ff.pin_fn == OSS_PIN_CLK) && q_ff.pin.oe;
    endproperty
    a_clk_pin: assert property (p_clk_pin) else $error("clock pin not driven");

    property p_clk_pin_out;
        (q_ff.pin_fn == OSS_PIN_CLK) |-> (q_ff.pin.out == q_ff.x4);
    endproperty
    a_clk_pin_out: assert property (p_clk_pin_out) else $error("pin not x4");

    property p_pin_gpio;
        (q_ff.pin_fn == OSS_PIN_GPIO) |-> (q_ff.pin.oe == $past(gpio_oe));
    endproperty
    a_pin_gpio: assert property (p_pin_gpio) else $error("pin not released");

    property p_ifs_resv;
        (wr && addr == `OSS_ADDR_CTRL && wdata[`OSS_CTRL_IFS_LSB +: 2] == `OSS_IFS_RESV)
            |=> $stable(q_ff.ifs);
    endproperty
    a_ifs_resv: assert property (p_ifs_resv) else $error("reserved ifs taken");
endmodule // oss_top

// >>> verification/oss_far_model.sv
// far-side model: oscillators, external clock pin source
// assumes the bench gates the external pin clock with ext_run
`timescale 1ns/100ps
module oss_far_model (
    input  wire logic int_en,
    input  wire logic amp_en,
    input  wire logic ext_run,
    output logic      int_clk,
    output logic      ext_clk,
    output logic      rc_clk,
    output logic      xtal_clk
);
    initial begin
        int_clk = 1'b0;
        ext_clk = 1'b0;
        rc_clk = 1'b0;
        xtal_clk = 1'b0;
    end
    // stopped oscillators rest low
    always #60 int_clk = int_en ? ~int_clk : 1'b0;
    always #45 ext_clk = ext_run ? ~ext_clk : 1'b0;
    always #70 rc_clk = ~rc_clk;
    always #55 xtal_clk = amp_en ? ~xtal_clk : 1'b0;
endmodule // oss_far_model

// >>> verification/tb.sv
// self-checking bench for oss_top
// assumes oss_far_model supplies the oscillator levels
`timescale 1ns/100ps
`include "oss_regs.svh"
module tb;
    logic       clk, rst, wr, rd, stop_mode, sys_osc_enable, gpio_out, gpio_oe, ext_run;
    logic [1:0] addr, internal_freq_select, crystal_range_select;
    logic [7:0] wdata, rdata, trim_register, v;
    logic       clk_times_four, clk_times_two, internal_osc_enable, crystal_amp_enable;
    logic       in_pin_clock_enable, clock_output_pin_out, clock_output_pin_oe;
    logic       ext_clock_engaged, int_clk, ext_clk, rc_clk, xtal_clk;
    int         n_fail, checks, ext_rises, a4, a2, ae;
    integer     seed;

    oss_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .internal_osc_clk(int_clk), .clock_input_pin(ext_clk),
        .rc_osc_clk(rc_clk), .crystal_clk(xtal_clk), .stop_mode(stop_mode),
        .sys_osc_enable(sys_osc_enable), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .clk_times_four(clk_times_four), .clk_times_two(clk_times_two),
        .internal_osc_enable(internal_osc_enable), .crystal_amp_enable(crystal_amp_enable),
        .internal_freq_select(internal_freq_select),
        .crystal_range_select(crystal_range_select), .trim_register(trim_register),
        .in_pin_clock_enable(in_pin_clock_enable), .clock_output_pin_out(clock_output_pin_out),
        .clock_output_pin_oe(clock_output_pin_oe), .ext_clock_engaged(ext_clock_engaged));

    oss_far_model far (.int_en(internal_osc_enable), .amp_en(crystal_amp_enable),
        .ext_run(ext_run), .int_clk(int_clk), .ext_clk(ext_clk), .rc_clk(rc_clk),
        .xtal_clk(xtal_clk));

    always #12.5 clk = ~clk;
    always @(posedge ext_clk) ext_rises++;

    function automatic logic [7:0] ctl(logic [1:0] s, logic [1:0] i, logic [1:0] r, logic q);
        return {s, i, r, q, 1'b0};
    endfunction

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk8(rdata, exp, what);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_eng(input logic lvl);
        int k;
        k = 0;
        while (ext_clock_engaged !== lvl && k < 400) begin
            settle(1);
            k++;
        end
        chk1(ext_clock_engaged, lvl, "engaged wait");
    endtask

    // rising edges of x4, x2 and the pin as seen at clk rate
    task automatic measure(input int n);
        logic p4, p2, pe;
        a4 = 0;
        a2 = 0;
        ae = 0;
        p4 = clk_times_four;
        p2 = clk_times_two;
        pe = ext_clk;
        repeat (n) begin
            settle(1);
            a4 += int'(clk_times_four === 1'b1 && p4 === 1'b0);
            a2 += int'(clk_times_two === 1'b1 && p2 === 1'b0);
            ae += int'(ext_clk === 1'b1 && pe === 1'b0);
            p4 = clk_times_four;
            p2 = clk_times_two;
            pe = ext_clk;
        end
    endtask

    task automatic tend(input string name);
        $display("test %s done", name);
    endtask

    task automatic summarize;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        #(25 * 30000);
        n_fail++;
        summarize;
    end

    initial begin
        seed = 32'hcfc8c759;
        clk = 1'b0;
        rst = 1'b1;
        {wr, rd, addr, wdata, stop_mode, sys_osc_enable, gpio_out, gpio_oe, ext_run} = '0;
        n_fail = 0;
        checks = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_chk(`OSS_ADDR_CTRL, ctl(`OSS_SRC_INT, `OSS_IFS_RESET, 2'h0, 1'b0), "ctrl");
        rd_chk(`OSS_ADDR_TRIM, `OSS_TRIM_RESET, "trim");
        rd_chk(`OSS_ADDR_CFG, 8'h00, "cfg");
        rd_chk(`OSS_ADDR_STATUS, 8'h0c, "status");
        chk1(ext_clock_engaged, 1'b0, "eng");
        chk1(in_pin_clock_enable, 1'b0, "in pin");
        tend("reset");
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : 8'($random(seed));
            wr_reg(`OSS_ADDR_TRIM, v);
            chk8(trim_register, v, "trim out");
            rd_chk(`OSS_ADDR_TRIM, v, "trim rd");
        end
        tend("trim");
        for (int i = 0; i < 4; i++) begin
            wr_reg(`OSS_ADDR_CTRL, ctl(`OSS_SRC_INT, 2'(i), 2'h0, 1'b0));
            v = (i == 3) ? 8'h02 : 8'(i);
            chk8({6'h00, internal_freq_select}, v, "ifs");
        end
        tend("ifs");
        gpio_out <= 1'($random(seed));
        gpio_oe <= 1'($random(seed));
        wr_reg(`OSS_ADDR_CFG, 8'h00);
        settle(3);
        chk1(clock_output_pin_oe, gpio_oe, "gpio oe");
        chk1(clock_output_pin_out, gpio_out, "gpio out");
        wr_reg(`OSS_ADDR_CFG, 8'h01);
        settle(3);
        chk1(clock_output_pin_oe, 1'b1, "clk oe");
        chk1(clock_output_pin_out, clk_times_four, "pin x4");
        measure(200);
        chk1(a4 > 0 && a2 * 2 >= a4 - 1 && a2 * 2 <= a4 + 1, 1'b1, "x2 half");
        tend("pin internal");
        wr_reg(`OSS_ADDR_CTRL, ctl(`OSS_SRC_EXT, 2'h2, 2'h0, 1'b0));
        settle(2);
        chk1(in_pin_clock_enable, 1'b1, "in pin ext");
        ext_run <= 1'b1;
        settle(40);
        ext_rises = 0;
        wr_reg(`OSS_ADDR_CTRL, ctl(`OSS_SRC_EXT, 2'h2, 2'h0, 1'b1));
        wait_eng(1'b1);
        chk1(ext_rises >= 2, 1'b1, "two edges");
        chk1(internal_osc_enable, 1'b1, "int still on");
        gpio_oe <= 1'b0;
        settle(3);
        chk1(internal_osc_enable, 1'b0, "int stopped");
        chk1(clock_output_pin_oe, 1'b0, "oe forced");
        rd_chk(`OSS_ADDR_CFG, 8'h00, "ocen forced");
        rd_chk(`OSS_ADDR_CTRL, ctl(`OSS_SRC_EXT, 2'h2, 2'h0, 1'b1) | 8'h01, "eng rd");
        measure(100);
        chk1(ae > 0 && a4 >= ae - 2 && a4 <= ae + 2, 1'b1, "x4 pin");
        wr_reg(`OSS_ADDR_CTRL, ctl(`OSS_SRC_INT, 2'h1, 2'h0, 1'b0));
        wait_eng(1'b0);
        ext_run <= 1'b0;
        chk1(internal_osc_enable, 1'b1, "int back");
        chk8({6'h00, internal_freq_select}, 8'h01, "ifs back");
        tend("external");
        wr_reg(`OSS_ADDR_CTRL, ctl(`OSS_SRC_XTAL, 2'h1, 2'h1, 1'b0));
        gpio_oe <= 1'b1;
        settle(3);
        chk1(crystal_amp_enable, 1'b1, "amp");
        chk1(clock_output_pin_oe, 1'b0, "amp pin");
        chk8({6'h00, crystal_range_select}, 8'h01, "range");
        settle(40);
        wr_reg(`OSS_ADDR_CTRL, ctl(`OSS_SRC_XTAL, 2'h1, 2'h1, 1'b1));
        wait_eng(1'b1);
        wr_reg(`OSS_ADDR_CTRL, ctl(`OSS_SRC_XTAL, 2'h1, 2'h2, 1'b1));
        chk8({6'h00, crystal_range_select}, 8'h01, "range held");
        wr_reg(`OSS_ADDR_CTRL, ctl(`OSS_SRC_INT, 2'h1, 2'h2, 1'b0));
        wait_eng(1'b0);
        tend("crystal");
        gpio_oe <= 1'b0;
        wr_reg(`OSS_ADDR_CFG, 8'h01);
        wr_reg(`OSS_ADDR_CTRL, ctl(`OSS_SRC_RC, 2'h1, 2'h0, 1'b0));
        settle(3);
        chk1(clock_output_pin_oe, 1'b1, "rc clk oe");
        chk1(in_pin_clock_enable, 1'b1, "rc in pin");
        wr_reg(`OSS_ADDR_CTRL, ctl(`OSS_SRC_INT, 2'h1, 2'h0, 1'b0));
        tend("rc");
        stop_mode <= 1'b1;
        settle(3);
        chk1(internal_osc_enable, 1'b0, "stop off");
        chk1(clk_times_four, 1'b0, "x4 stopped");
        wr_reg(`OSS_ADDR_CFG, 8'h03);
        settle(2);
        chk1(internal_osc_enable, 1'b1, "stop keep");
        wr_reg(`OSS_ADDR_CFG, 8'h01);
        sys_osc_enable <= 1'b1;
        settle(3);
        chk1(internal_osc_enable, 1'b1, "stop sys en");
        stop_mode <= 1'b0;
        tend("stop");
        summarize;
    end
endmodule // tb
